// ==== rtl/vpc_pkg.sv ====
package vpc_pkg;

	// Packet geometry
	localparam int NUM_SLOTS = 8;
	localparam int NUM_UNITS = 8;
	localparam int NUM_EX    = 10;
	localparam int UNIT_W    = 3;
	localparam int SLOT_W    = 8;
	localparam int PKT_W     = NUM_SLOTS * SLOT_W;
	localparam int ADDR_W    = 32;
	localparam int CLS_W     = 4;
	localparam int RD_W      = 4;
	localparam int WR_W      = 2;

	// Slot descriptor layout: {class, unit, parallel}
	localparam int SLOT_PAR_BIT  = 0;
	localparam int SLOT_UNIT_LSB = 1;
	localparam int SLOT_CLS_LSB  = 4;

	localparam logic [2:0]        LAST_SLOT  = 3'h7;
	localparam logic [2:0]        FIRST_SLOT = 3'h0;
	localparam logic [ADDR_W-1:0] PKT_BYTES  = 32'h00000020;
	localparam logic [ADDR_W-1:0] PC_RESET   = 32'h00000000;

	// Execute stage numbers
	localparam int STG1  = 1;
	localparam int STG2  = 2;
	localparam int STG3  = 3;
	localparam int STG4  = 4;
	localparam int STG5  = 5;
	localparam int STG6  = 6;
	localparam int STG7  = 7;
	localparam int STG8  = 8;
	localparam int STG9  = 9;
	localparam int STG10 = 10;

	// Read strobes: bit0 src1 low, bit1 src1 high, bit2 src2 low, bit3 src2 high
	localparam logic [RD_W-1:0] RD_NONE      = 4'h0;
	localparam logic [RD_W-1:0] RD_LO        = 4'h5;
	localparam logic [RD_W-1:0] RD_HI        = 4'hA;
	localparam logic [RD_W-1:0] RD_S1LO_S2HI = 4'h9;
	localparam logic [RD_W-1:0] RD_S1HI_S2LO = 4'h6;

	// Write strobes: bit0 low word, bit1 high word
	localparam logic [WR_W-1:0] WR_NONE = 2'h0;
	localparam logic [WR_W-1:0] WR_LO   = 2'h1;
	localparam logic [WR_W-1:0] WR_HI   = 2'h2;

	typedef enum logic [CLS_W-1:0] {
		CLS_SINGLE, CLS_MUL16, CLS_STORE, CLS_LOAD, CLS_BRANCH, CLS_DP2,
		CLS_FOUR, CLS_I2D, CLS_DPCMP, CLS_DADD, CLS_IMUL, CLS_IMULD,
		CLS_DMUL, CLS_SDMUL, CLS_SPMUL, CLS_NOP
	} vpc_cls_type;

	typedef struct packed {
		logic        v;
		vpc_cls_type cls;
		logic        clamp_occurred_flag;
	} vpc_entry_type;

endpackage : vpc_pkg

// ==== rtl/vpc_unit_if.sv ====
interface vpc_unit_if;
	import vpc_pkg::*;

	// Issue side, driven by the phase controller
	logic        issue;
	vpc_cls_type cls;
	logic        cond;
	logic        clamp_occurred_flag;
	// Schedule side, driven by the unit tracker
	logic            branch_now;
	logic [RD_W-1:0] rd;
	logic [WR_W-1:0] wr;
	logic            agen;
	logic            base_wb;
	logic            mem_send;
	logic            store_data;
	logic            mem_access;
	logic            load_arrive;
	logic            clamp_set;

	modport ctrl (
		output issue, cls, cond, clamp_occurred_flag,
		input  branch_now, rd, wr, agen, base_wb, mem_send, store_data,
		input  mem_access, load_arrive, clamp_set
	);
	modport sched (
		input  issue, cls, cond, clamp_occurred_flag,
		output branch_now, rd, wr, agen, base_wb, mem_send, store_data,
		output mem_access, load_arrive, clamp_set
	);

endinterface : vpc_unit_if

// ==== rtl/vpc_unit_sched.sv ====
module vpc_unit_sched
	import vpc_pkg::*;
#(
	parameter int DEPTH = NUM_EX
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	vpc_unit_if.sched bus
);

	vpc_entry_type   e_q [1:DEPTH];
	vpc_entry_type   e_d [1:DEPTH];
	logic [RD_W-1:0] rd_d, rd_q;
	logic [WR_W-1:0] wr_d, wr_q;
	logic            agen_d, agen_q, bwb_d, bwb_q, send_d, send_q, st_d, st_q;
	logic            acc_d, acc_q, arr_d, arr_q, clamp_d;

	// Operand reads of one class in one stage
	function automatic logic [RD_W-1:0] rd_mask(input vpc_cls_type c, input int k);
		logic [RD_W-1:0] m;
		m = RD_NONE;
		if (k == STG1)
			m = RD_LO;
		else if (k == STG2 && (c == CLS_DPCMP || c == CLS_DADD))
			m = RD_HI;
		else if (k == STG2 && (c == CLS_SDMUL || c == CLS_DMUL))
			m = RD_S1LO_S2HI;
		else if (k == STG3 && c == CLS_DMUL)
			m = RD_S1HI_S2LO;
		else if (k == STG4 && c == CLS_DMUL)
			m = RD_HI;
		else if (k <= STG4 && (c == CLS_IMUL || c == CLS_IMULD))
			m = RD_LO;
		return m;
	endfunction : rd_mask

	// Result writes of one class in one stage; none in stage eight
	function automatic logic [WR_W-1:0] wr_mask(input vpc_cls_type c, input int k);
		logic [WR_W-1:0] m;
		m = WR_NONE;
		unique case (c)
			CLS_SINGLE:   m = (k == STG1) ? WR_LO : WR_NONE;
			CLS_MUL16,
			CLS_DPCMP:    m = (k == STG2) ? WR_LO : WR_NONE;
			CLS_DP2:      m = (k == STG1) ? WR_LO : ((k == STG2) ? WR_HI : WR_NONE);
			CLS_FOUR:     m = (k == STG4) ? WR_LO : WR_NONE;
			CLS_I2D,
			CLS_SPMUL:    m = (k == STG4) ? WR_LO : ((k == STG5) ? WR_HI : WR_NONE);
			CLS_LOAD:     m = (k == STG5) ? WR_LO : WR_NONE;
			CLS_DADD,
			CLS_SDMUL:    m = (k == STG6) ? WR_LO : ((k == STG7) ? WR_HI : WR_NONE);
			CLS_IMUL:     m = (k == STG9) ? WR_LO : WR_NONE;
			CLS_IMULD,
			CLS_DMUL:     m = (k == STG9) ? WR_LO : ((k == STG10) ? WR_HI : WR_NONE);
			CLS_STORE,
			CLS_BRANCH,
			CLS_NOP:      m = WR_NONE;
		endcase
		return m;
	endfunction : wr_mask

	function automatic logic is_mem(input vpc_cls_type c);
		return (c == CLS_LOAD) || (c == CLS_STORE);
	endfunction : is_mem

	assign bus.branch_now = bus.issue && bus.cond && (bus.cls == CLS_BRANCH);

	// Next stage contents and the strobes of the cycle they land in
	always_comb
	begin
		e_d[STG1].v   = bus.issue & bus.cond;
		e_d[STG1].cls = bus.cls;
		e_d[STG1].clamp_occurred_flag = 1'b0;
		for (int k = STG2; k <= DEPTH; k++)
			e_d[k] = e_q[k-1];
		rd_d = bus.issue ? rd_mask(bus.cls, STG1) : RD_NONE;
		wr_d = WR_NONE;
		for (int k = STG1; k <= DEPTH; k++)
		begin
			if (e_d[k].v)
			begin
				if (k > STG1)
					rd_d = rd_d | rd_mask(e_d[k].cls, k);
				wr_d = wr_d | wr_mask(e_d[k].cls, k);
			end
		end
		agen_d  = bus.issue & is_mem(bus.cls);
		bwb_d   = e_d[STG1].v & is_mem(e_d[STG1].cls);
		send_d  = e_d[STG2].v & is_mem(e_d[STG2].cls);
		st_d    = e_d[STG2].v & (e_d[STG2].cls == CLS_STORE);
		acc_d   = e_d[STG3].v & is_mem(e_d[STG3].cls);
		arr_d   = e_d[STG4].v & (e_d[STG4].cls == CLS_LOAD);
		// short multiply a stage later
		// Unregistered here: the flag flop upstream makes it visible next stage
		clamp_d = bus.clamp_occurred_flag && ((e_q[STG1].v && e_q[STG1].cls == CLS_SINGLE) ||
		          (e_q[STG2].v && e_q[STG2].cls == CLS_MUL16));
	end

	// Stage shift; no stall input by design, nothing ever waits
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			for (int k = STG1; k <= DEPTH; k++)
				e_q[k] <= '{v: 1'b0, cls: CLS_NOP, clamp_occurred_flag: 1'b0};
			rd_q    <= RD_NONE;
			wr_q    <= WR_NONE;
			agen_q  <= 1'b0;
			bwb_q   <= 1'b0;
			send_q  <= 1'b0;
			st_q    <= 1'b0;
			acc_q   <= 1'b0;
			arr_q   <= 1'b0;
		end
		else
		begin
			e_q     <= e_d;
			rd_q    <= rd_d;
			wr_q    <= wr_d;
			agen_q  <= agen_d;
			bwb_q   <= bwb_d;
			send_q  <= send_d;
			st_q    <= st_d;
			acc_q   <= acc_d;
			arr_q   <= arr_d;
		end
	end

	// Strobes straight from flops, except clamp_set, which comes unregistered from clamp_d
	assign bus.rd          = rd_q;
	assign bus.wr          = wr_q;
	assign bus.agen        = agen_q;
	assign bus.base_wb     = bwb_q;
	assign bus.mem_send    = send_q;
	assign bus.store_data  = st_q;
	assign bus.mem_access  = acc_q;
	assign bus.load_arrive = arr_q;
	assign bus.clamp_set   = clamp_d;

endmodule : vpc_unit_sched

// ==== rtl/vpc_phase_ctrl.sv ====
module vpc_phase_ctrl
	import vpc_pkg::*;
(
	input  wire logic                       clk_i,
	input  wire logic                       resetn_i,
	output logic       [ADDR_W-1:0]         fetch_addr_o,
	output logic                            fetch_req_o,
	input  wire logic  [PKT_W-1:0]          fetch_pkt_i,
	input  wire logic  [ADDR_W-1:0]         branch_target_i,
	input  wire logic  [NUM_UNITS-1:0]      pred_true_i,
	input  wire logic  [NUM_UNITS-1:0]      sat_i,
	input  wire logic                       clamp_clear_i,
	output logic       [NUM_UNITS-1:0]      dc_valid_o,
	output logic       [NUM_UNITS*RD_W-1:0] rd_strobe_o,
	output logic       [NUM_UNITS*WR_W-1:0] wr_strobe_o,
	output logic       [NUM_UNITS-1:0]      addr_gen_o,
	output logic       [NUM_UNITS-1:0]      base_wb_o,
	output logic       [NUM_UNITS-1:0]      dmem_send_o,
	output logic       [NUM_UNITS-1:0]      dmem_store_o,
	output logic       [NUM_UNITS-1:0]      dmem_access_o,
	output logic       [NUM_UNITS-1:0]      load_arrive_o,
	output logic                            clamp_occurred_flag_o
);

	// Fetch phase registers
	logic [ADDR_W-1:0] pc_q, pc_d;
	logic [ADDR_W-1:0] ps_addr_q, ps_addr_d;
	logic              ps_v_q, ps_v_d;
	logic              pw_v_q, pw_v_d;
	logic              pr_v_q, pr_v_d;
	logic [PKT_W-1:0]  pr_pkt_q, pr_pkt_d;
	logic              req_q, req_d;

	// Dispatch and decode registers
	logic                dp_v_q, dp_v_d;
	logic [PKT_W-1:0]    dp_pkt_q, dp_pkt_d;
	logic [2:0]          dp_start_q, dp_start_d;
	logic [2:0]          ep_end;
	logic                pkt_done;
	logic                fetch_adv;
	logic [NUM_UNITS-1:0] dc_v_q, dc_v_d;
	vpc_cls_type         dc_cls_q [NUM_UNITS];
	vpc_cls_type         dc_cls_d [NUM_UNITS];

	// Flag and unit collection
	logic                 clamp_q, clamp_d;
	logic [NUM_UNITS-1:0] br_vec;
	logic [NUM_UNITS-1:0] clamp_vec;

	vpc_unit_if u_if [NUM_UNITS] ();

	function automatic vpc_cls_type slot_cls(input logic [PKT_W-1:0] p, input int i);
		return vpc_cls_type'(p[i*SLOT_W+SLOT_CLS_LSB +: CLS_W]);
	endfunction : slot_cls

	function automatic logic [UNIT_W-1:0] slot_unit(input logic [PKT_W-1:0] p,
	                                               input int i);
		return p[i*SLOT_W+SLOT_UNIT_LSB +: UNIT_W];
	endfunction : slot_unit

	// Execute packet boundary: first slot at or after start with parallel bit clear
	always_comb
	begin
		logic found;
		found  = 1'b0;
		ep_end = LAST_SLOT;
		for (int i = 0; i < NUM_SLOTS; i++)
		begin
			if (!found && i >= int'(dp_start_q) && !dp_pkt_q[i*SLOT_W+SLOT_PAR_BIT])
			begin
				ep_end = 3'(i);
				found  = 1'b1;
			end
		end
		pkt_done = !dp_v_q || (ep_end == LAST_SLOT);
	end

	assign fetch_adv = pkt_done;

	// Dispatch next state and unit routing
	always_comb
	begin
		dc_v_d = '0;
		for (int u = 0; u < NUM_UNITS; u++)
			dc_cls_d[u] = CLS_NOP;
		if (dp_v_q)
		begin
			for (int i = 0; i < NUM_SLOTS; i++)
			begin
				if (i >= int'(dp_start_q) && i <= int'(ep_end) &&
				    slot_cls(dp_pkt_q, i) != CLS_NOP)
				begin
					dc_v_d[slot_unit(dp_pkt_q, i)]   = 1'b1;
					dc_cls_d[slot_unit(dp_pkt_q, i)] = slot_cls(dp_pkt_q, i);
				end
			end
		end
		if (pkt_done)
		begin
			dp_v_d     = pr_v_q;
			dp_pkt_d   = pr_pkt_q;
			dp_start_d = FIRST_SLOT;
		end
		else
		begin
			dp_v_d     = dp_v_q;
			dp_pkt_d   = dp_pkt_q;
			dp_start_d = 3'(ep_end + 3'h1);
		end
	end

	// Fetch next state; the program counter is the generate phase itself
	always_comb
	begin
		pc_d      = pc_q;
		ps_addr_d = ps_addr_q;
		ps_v_d    = ps_v_q;
		pw_v_d    = pw_v_q;
		pr_v_d    = pr_v_q;
		pr_pkt_d  = pr_pkt_q;
		req_d     = 1'b0;
		if (fetch_adv)
		begin
			ps_addr_d = pc_q;
			ps_v_d    = 1'b1;
			pw_v_d    = ps_v_q;
			pr_v_d    = pw_v_q;
			pr_pkt_d  = fetch_pkt_i;
			pc_d      = pc_q + PKT_BYTES;
			req_d     = 1'b1;
		end
		if (|br_vec)
			pc_d = branch_target_i;
	end

	// Sticky clamp flag; a new event beats a clear in the same cycle
	always_comb
	begin
		clamp_d = (clamp_q & ~clamp_clear_i) | (|clamp_vec);
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pc_q       <= PC_RESET;
			ps_addr_q  <= PC_RESET;
			ps_v_q     <= 1'b0;
			pw_v_q     <= 1'b0;
			pr_v_q     <= 1'b0;
			pr_pkt_q   <= '0;
			req_q      <= 1'b0;
			dp_v_q     <= 1'b0;
			dp_pkt_q   <= '0;
			dp_start_q <= FIRST_SLOT;
			dc_v_q     <= '0;
			for (int u = 0; u < NUM_UNITS; u++)
				dc_cls_q[u] <= CLS_NOP;
			clamp_q    <= 1'b0;
		end
		else
		begin
			pc_q       <= pc_d;
			ps_addr_q  <= ps_addr_d;
			ps_v_q     <= ps_v_d;
			pw_v_q     <= pw_v_d;
			pr_v_q     <= pr_v_d;
			pr_pkt_q   <= pr_pkt_d;
			req_q      <= req_d;
			dp_v_q     <= dp_v_d;
			dp_pkt_q   <= dp_pkt_d;
			dp_start_q <= dp_start_d;
			dc_v_q     <= dc_v_d;
			dc_cls_q   <= dc_cls_d;
			clamp_q    <= clamp_d;
		end
	end

	// One execute tracker per functional unit; decode always issues next cycle
	for (genvar g = 0; g < NUM_UNITS; g++)
	begin : g_unit
		assign u_if[g].issue = dc_v_q[g];
		assign u_if[g].cls   = dc_cls_q[g];
		assign u_if[g].cond  = pred_true_i[g];
		assign u_if[g].clamp_occurred_flag   = sat_i[g];

		vpc_unit_sched #(
			.DEPTH (NUM_EX)
		) u_sched (
			.clk_i    (clk_i),
			.resetn_i (resetn_i),
			.bus      (u_if[g])
		);

		assign br_vec[g]                      = u_if[g].branch_now;
		assign clamp_vec[g]                   = u_if[g].clamp_set;
		assign rd_strobe_o[g*RD_W +: RD_W]    = u_if[g].rd;
		assign wr_strobe_o[g*WR_W +: WR_W]    = u_if[g].wr;
		assign addr_gen_o[g]                  = u_if[g].agen;
		assign base_wb_o[g]                   = u_if[g].base_wb;
		assign dmem_send_o[g]                 = u_if[g].mem_send;
		assign dmem_store_o[g]                = u_if[g].store_data;
		assign dmem_access_o[g]               = u_if[g].mem_access;
		assign load_arrive_o[g]               = u_if[g].load_arrive;
	end

	// Registered outputs
	assign fetch_addr_o          = ps_addr_q;
	assign fetch_req_o           = req_q;
	assign dc_valid_o            = dc_v_q;
	assign clamp_occurred_flag_o = clamp_q;

endmodule : vpc_phase_ctrl

// ==== test/vpc_phase_ctrl_chk.sv ====
module vpc_phase_ctrl_chk
	import vpc_pkg::*;
(
	input wire logic                      clk_i,
	input wire logic                      resetn_i,
	input wire logic [ADDR_W-1:0]         fetch_addr_o,
	input wire logic                      fetch_req_o,
	input wire logic [ADDR_W-1:0]         branch_target_i,
	input wire logic [NUM_UNITS-1:0]      sat_i,
	input wire logic                      clamp_clear_i,
	input wire logic [NUM_UNITS-1:0]      dc_valid_o,
	input wire logic [NUM_UNITS*RD_W-1:0] rd_strobe_o,
	input wire logic [NUM_UNITS-1:0]      addr_gen_o,
	input wire logic [NUM_UNITS-1:0]      base_wb_o,
	input wire logic [NUM_UNITS-1:0]      dmem_send_o,
	input wire logic [NUM_UNITS-1:0]      dmem_store_o,
	input wire logic [NUM_UNITS-1:0]      dmem_access_o,
	input wire logic [NUM_UNITS-1:0]      load_arrive_o,
	input wire logic                      clamp_occurred_flag_o
);
	// One clock domain, so one default clock and reset
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	// Sequential fetch steps one packet, unless redirected
	a_addr_step: assert property (
		fetch_req_o && $past(fetch_req_o) |-> fetch_addr_o == $past(fetch_addr_o) + PKT_BYTES
			|| fetch_addr_o == $past(branch_target_i, 2))
		else $error("fetch address did not step");
	a_addr_hold: assert property (
		!fetch_req_o |-> $stable(fetch_addr_o))
		else $error("fetch address moved while held");
	a_stall_bound: assert property (
		$fell(fetch_req_o) |-> ##[1:8] fetch_req_o)
		else $error("fetch held too long");
	a_gen_after_dc: assert property (
		(addr_gen_o & ~$past(dc_valid_o)) == '0)
		else $error("address generated outside stage one");
	a_base_in_e1: assert property (
		(base_wb_o & ~addr_gen_o) == '0)
		else $error("base write without address generation");
	a_send_after: assert property (
		(dmem_send_o & ~$past(base_wb_o)) == '0)
		else $error("memory send not one cycle after stage one");
	a_store_send: assert property (
		(dmem_store_o & ~dmem_send_o) == '0)
		else $error("store data without address");
	a_access_after: assert property (
		(dmem_access_o & ~$past(dmem_send_o)) == '0)
		else $error("memory access not after send");
	a_arrive_after: assert property (
		(load_arrive_o & ~$past(dmem_access_o)) == '0)
		else $error("load data not after access");
	a_clamp_cause: assert property (
		$rose(clamp_occurred_flag_o) |-> $past(|sat_i))
		else $error("clamp flag set without saturation");
	a_clamp_clear: assert property (
		clamp_clear_i && sat_i == '0 |=> !clamp_occurred_flag_o)
		else $error("clamp flag not cleared");
	a_clamp_sticky: assert property (
		clamp_occurred_flag_o && !clamp_clear_i |=> clamp_occurred_flag_o)
		else $error("clamp flag lost");

	// Every issued instruction reads low sources in stage one
	for (genvar u = 0; u < NUM_UNITS; u++)
	begin : g_unit
		a_read_in_e1: assert property (
			dc_valid_o[u] |=> (rd_strobe_o[u*RD_W +: RD_W] & RD_LO) == RD_LO)
			else $error("stage one read missing");
	end

	c_full_packet: cover property (dc_valid_o == 8'hFF);
	c_load_arrive: cover property (load_arrive_o != '0);
	c_clamp_set: cover property ($rose(clamp_occurred_flag_o));
	c_fetch_stall: cover property ($fell(fetch_req_o));
endmodule : vpc_phase_ctrl_chk

bind vpc_phase_ctrl vpc_phase_ctrl_chk vpc_phase_ctrl_chk_i (.clk_i, .resetn_i, .fetch_addr_o,
	.fetch_req_o, .branch_target_i, .sat_i, .clamp_clear_i, .dc_valid_o, .rd_strobe_o,
	.addr_gen_o, .base_wb_o, .dmem_send_o, .dmem_store_o, .dmem_access_o, .load_arrive_o,
	.clamp_occurred_flag_o);

// ==== test/vpc_prog_mem.sv ====
module vpc_prog_mem
	import vpc_pkg::*;
(
	input  wire logic             clk_i,
	input  wire logic             resetn_i,
	input  wire logic             req_i,
	input  wire logic             load_i,
	input  wire logic [PKT_W-1:0] pkt_i,
	output logic      [PKT_W-1:0] pkt_o
);
	// Idle word: nops parked on unit 7, one execute packet, so no stall
	localparam logic [PKT_W-1:0] IDLE_PKT = 64'hFEFFFFFFFFFFFFFF;

	// access in wait phase
	// Answer lands the cycle after a request and holds until the next one
	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			pkt_o <= IDLE_PKT;
		else if (req_i)
			pkt_o <= load_i ? pkt_i : IDLE_PKT;
	end
endmodule : vpc_prog_mem

// ==== test/vpc_phase_ctrl_test.sv ====
module vpc_phase_ctrl_test
	import vpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	localparam logic [PKT_W-1:0] IDLE_PKT = 64'hFEFFFFFFFFFFFFFF;
	localparam logic [ADDR_W-1:0] FAR_TGT = 32'hFFFFFC00;
	// Per class, one nibble per stage, stage one lowest
	localparam logic [39:0] RDT [15] = '{40'h5, 40'h5, 40'h5, 40'h5, 40'h5, 40'h5, 40'h5,
		40'h5, 40'hA5, 40'hA5, 40'h5555, 40'h5555, 40'hA695, 40'h95, 40'h5};
	localparam logic [39:0] WRT [15] = '{40'h1, 40'h10, 40'h0, 40'h10000, 40'h0, 40'h21,
		40'h1000, 40'h21000, 40'h10, 40'h2100000, 40'h100000000, 40'h2100000000,
		40'h2100000000, 40'h2100000, 40'h21000};

	logic                      clk_i, resetn_i, fetch_req_o, clamp_clear_i, ld;
	logic [ADDR_W-1:0]         fetch_addr_o, branch_target_i;
	logic [PKT_W-1:0]          fetch_pkt_i, ld_pkt;
	logic [NUM_UNITS-1:0]      pred_true_i, sat_i, dc_valid_o, addr_gen_o, base_wb_o;
	logic [NUM_UNITS-1:0]      dmem_send_o, dmem_store_o, dmem_access_o, load_arrive_o;
	logic [NUM_UNITS*RD_W-1:0] rd_strobe_o;
	logic [NUM_UNITS*WR_W-1:0] wr_strobe_o;
	logic                      clamp_occurred_flag_o;
	int                        num_errors, num_checks, stalls;

	vpc_phase_ctrl vpc_phase_ctrl_i (.clk_i, .resetn_i, .fetch_addr_o, .fetch_req_o,
		.fetch_pkt_i, .branch_target_i, .pred_true_i, .sat_i, .clamp_clear_i, .dc_valid_o,
		.rd_strobe_o, .wr_strobe_o, .addr_gen_o, .base_wb_o, .dmem_send_o, .dmem_store_o,
		.dmem_access_o, .load_arrive_o, .clamp_occurred_flag_o);
	vpc_prog_mem vpc_prog_mem_i (.clk_i, .resetn_i, .req_i(fetch_req_o), .load_i(ld),
		.pkt_i(ld_pkt), .pkt_o(fetch_pkt_i));

	// Free-running clock
	always #50 clk_i = ~clk_i;

	// Cycles where fetch sat without a request
	always @(posedge clk_i)
		if (resetn_i && !fetch_req_o)
			stalls++;

	task automatic check(input string what, input logic [63:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check

	task automatic complete_run;
		if (num_errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	// Hand one packet to memory, wait for its first decode slots
	task automatic inject(input logic [PKT_W-1:0] p, input logic [7:0] m);
		@(posedge clk_i);
		ld <= 1'b1;
		ld_pkt <= p;
		@(posedge clk_i);
		ld <= 1'b0;
		#1;
		for (int n = 0; n < 12 && dc_valid_o !== m; n++)
			@(posedge clk_i) #1;
		check("dispatch mask", dc_valid_o, m);
	endtask : inject

	task automatic sc_reset;
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1;
		check("idle in reset", {fetch_req_o, dc_valid_o, clamp_occurred_flag_o}, 0);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i) #1;
			check("fetch step", {fetch_req_o, fetch_addr_o}, {1'b1, 32'(32 * i)});
		end
	endtask : sc_reset

	// Stage-by-stage strobes of one instruction alone in flight
	task automatic sc_class(input vpc_cls_type c, input logic p);
		logic [2:0] u;
		logic       ls;
		u = 3'(int'(c) % 7);
		ls = (c == CLS_LOAD) || (c == CLS_STORE);
		@(posedge clk_i);
		pred_true_i <= {8{p}};
		inject({IDLE_PKT[63:8], c, u, 1'b1}, 8'h01 << u);
		for (int k = 1; k <= 10; k++)
		begin
			@(posedge clk_i) #1;
			check("rd", rd_strobe_o[u*4 +: 4], p ? RDT[c][4*k-4 +: 4] : (k == 1 ? RD_LO : 0));
			check("wr", wr_strobe_o[u*2 +: 2], p ? WRT[c][4*k-4 +: 2] : 0);
			check("mem", {addr_gen_o[u], base_wb_o[u], dmem_send_o[u], dmem_store_o[u],
				dmem_access_o[u], load_arrive_o[u]}, {ls && k == 1, ls && p && k == 1,
				ls && p && k == 2, c == CLS_STORE && p && k == 2, ls && p && k == 3,
				c == CLS_LOAD && p && k == 4});
		end
	endtask : sc_class

	task automatic sc_branch(input logic p);
		@(posedge clk_i);
		pred_true_i <= {8{p}};
		branch_target_i <= FAR_TGT;
		inject({IDLE_PKT[63:8], CLS_BRANCH, 3'h2, 1'b1}, 8'h04);
		repeat (2) @(posedge clk_i);
		#1;
		check("branch fetch", fetch_addr_o == FAR_TGT, p);
		@(posedge clk_i) #1;
		check("after branch", fetch_addr_o == FAR_TGT + PKT_BYTES, p);
	endtask : sc_branch

	// Packet split into n execute packets stalls fetch n-1 cycles
	task automatic sc_split(input logic [PKT_W-1:0] p, input int n, input logic [63:0] m);
		stalls = 0;
		inject(p, m[7:0]);
		for (int i = 1; i < n; i++)
		begin
			@(posedge clk_i) #1;
			check("next packet", dc_valid_o, m[8*i +: 8]);
		end
		repeat (3) @(posedge clk_i);
		#1;
		check("fetch hold", stalls, n - 1);
	endtask : sc_split

	task automatic sc_clamp(input vpc_cls_type c, input logic p, input int s);
		@(posedge clk_i);
		clamp_clear_i <= 1'b1;
		pred_true_i <= {8{p}};
		@(posedge clk_i);
		clamp_clear_i <= 1'b0;
		#1;
		check("flag clear", clamp_occurred_flag_o, 0);
		inject({IDLE_PKT[63:8], c, 3'h1, 1'b1}, 8'h02);
		for (int k = 1; k <= 4; k++)
		begin
			@(posedge clk_i);
			sat_i <= (k == s) ? 8'h02 : 8'h00;
			#1;
			check("clamp flag", clamp_occurred_flag_o, p && k > s);
		end
	endtask : sc_clamp

	initial
	begin
		repeat (4000) @(posedge clk_i);
		num_errors++;
		complete_run();
	end

	initial
	begin
		clk_i = 1'b0;
		resetn_i = 1'b0;
		clamp_clear_i = 1'b0;
		ld = 1'b0;
		ld_pkt = IDLE_PKT;
		branch_target_i = '0;
		pred_true_i = '0;
		sat_i = '0;
		sc_reset();
		for (int c = 0; c < 15; c++)
		begin
			sc_class(vpc_cls_type'(c), 1'b1);
			sc_class(vpc_cls_type'(c), 1'b0);
		end
		sc_branch(1'b0);
		sc_branch(1'b1);
		sc_split(64'h0E0D0B0907050301, 1, 64'hFF);
		sc_split(64'hFE0D0B0907040301, 2, 64'h7807);
		sc_split(64'h0E0C0A0806040200, 8, 64'h8040201008040201);
		sc_clamp(CLS_SINGLE, 1'b0, 1);
		sc_clamp(CLS_MUL16, 1'b1, 2);
		sc_clamp(CLS_SINGLE, 1'b1, 1);
		sc_reset();
		complete_run();
	end
endmodule : vpc_phase_ctrl_test
